// ==== hw/tpi_pkg.sv ====
// Constants shared by the multiplexed port interface and its slot sequencer
package tpi_pkg;

  // ===========================================================================
  // Clocking and slot timing
  localparam int SYS_CLK_MHZ     = 100;
  localparam int MUX_CLK_MHZ     = 20;
  localparam int MUX_DIV         = SYS_CLK_MHZ / MUX_CLK_MHZ;
  localparam int MUX_HIGH_PH     = MUX_DIV / 2;
  localparam int FRAME_PERIOD_NS = 400;
  localparam int FRAME_CYCLES    = FRAME_PERIOD_NS * SYS_CLK_MHZ / 1000;
  localparam int NUM_PORTS       = FRAME_CYCLES / MUX_DIV;
  localparam int SLOT_W          = $clog2(NUM_PORTS);
  localparam int PH_W            = $clog2(MUX_DIV);

  // Phase of the last system cycle in a slot, and of the falling-edge launch
  localparam logic [PH_W-1:0]   PH_LAST   = PH_W'(MUX_DIV - 1);
  localparam logic [PH_W-1:0]   PH_LAUNCH = PH_W'(MUX_HIGH_PH - 1);
  localparam logic [PH_W-1:0]   PH_HIGH   = PH_W'(MUX_HIGH_PH);
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(NUM_PORTS - 1);
  localparam logic [SLOT_W-1:0] MARK_PORT = 3'h0;
  localparam logic [SLOT_W-1:0] RX_LEAD   = 3'h2;

  // ===========================================================================
  // Advertisement used when half duplex is forced
  localparam logic [3:0] ADV_HALF_ONLY = 4'h1;

  // ===========================================================================
  // Register map (byte addresses)
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_ADV      = 8'h10;

  // Control, status and interrupt fields
  localparam int   CTRL_RUN_BIT  = 0;
  localparam logic CTRL_RUN_RST  = 1'h1;
  localparam int   ST_INV_LSB    = 0;
  localparam int   ST_ACT_LSB    = 8;
  localparam int   ST_FORCE_BIT  = 16;
  localparam int   ST_SLOT_LSB   = 17;
  localparam int   IRQ_W         = 3;
  localparam int   IRQ_FORCE_EDG = 0;
  localparam int   IRQ_COLL      = 1;
  localparam int   IRQ_ADV_LATCH = 2;

  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  localparam logic       HRESP_OKAY  = 1'h0;
  localparam int         HTRANS_ACT  = 1;

endpackage

// ==== hw/tpi_slot_seq.sv ====
// Divider that makes the shared port clock, slot number and frame marker
`timescale 1ns/1ps

module tpi_slot_seq
  import tpi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              run,
  output logic      [PH_W-1:0]   phase,
  output logic      [SLOT_W-1:0] slot,
  output logic                   mux_clk,
  output logic                   marker
);

  typedef struct packed {
    logic [PH_W-1:0]   ph;
    logic [SLOT_W-1:0] slot;
    logic              clk_o;
    logic              mark;
  } tpi_seq_s;

  tpi_seq_s st_r;
  tpi_seq_s st_nxt;

  // ===========================================================================
  // Phase and slot stepping
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      // Stopped: clock low, ready to open slot 0 on restart
      st_nxt.ph    = PH_LAST;
      st_nxt.slot  = SLOT_LAST;
    end else if (st_r.ph == PH_LAST) begin
      st_nxt.ph    = '0;
      st_nxt.slot  = (st_r.slot == SLOT_LAST) ? '0
                                               : SLOT_W'(st_r.slot + 1'b1);
    end else begin
      st_nxt.ph    = PH_W'(st_r.ph + 1'b1);
    end
    st_nxt.clk_o = run && (st_nxt.ph < PH_HIGH);
    st_nxt.mark  = run && (st_nxt.slot == MARK_PORT);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '{ph: PH_LAST, slot: SLOT_LAST, clk_o: 1'b0, mark: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phase   = st_r.ph;
  assign slot    = st_r.slot;
  assign mux_clk = st_r.clk_o;
  assign marker  = st_r.mark;

endmodule

// ==== hw/tpi_mux_if.sv ====
// Device end of the eight-port time-multiplexed controller interface
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps

module tpi_mux_if
  import tpi_pkg::*;
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST_B,
  // AHB-Lite slave
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic      [31:0]            HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  output logic                        IRQ,
  // Controller-side pins
  output logic                        MUX_PORT_CLOCK,
  output logic                        SLOT_FRAME_MARKER,
  output logic      [3:0]             RX_NIBBLE,
  output logic                        RX_NIBBLE_VALID,
  output logic                        SLOT_COLLISION,
  output logic                        SLOT_CARRIER_SENSE,
  output logic                        SLOT_FULL_DUPLEX_FLAG,
  output logic                        SLOT_LINK_UP,
  input  wire logic                   HALF_DUPLEX_FORCE_IN,
  input  wire logic [3:0]             TX_NIBBLE,
  input  wire logic                   TX_NIBBLE_VALID,
  // Port engine side, one bit or nibble per port, except the shared transmit hand-off
  input  wire logic [NUM_PORTS*4-1:0] PORT_RX_DATA,
  input  wire logic [NUM_PORTS-1:0]   PORT_RX_VALID,
  input  wire logic [NUM_PORTS-1:0]   PORT_COLLISION,
  input  wire logic [NUM_PORTS-1:0]   PORT_CARRIER,
  input  wire logic [NUM_PORTS-1:0]   PORT_LINK,
  input  wire logic [NUM_PORTS-1:0]   PORT_FULL_DUPLEX,
  input  wire logic [NUM_PORTS-1:0]   PORT_ADV_LATCH,
  output logic      [3:0]             PORT_TX_DATA,
  output logic                        PORT_TX_VALID,
  output logic      [SLOT_W-1:0]      PORT_TX_NUM,
  output logic                        PORT_TX_STROBE,
  output logic      [NUM_PORTS*4-1:0] PORT_ADV_MODES,
  output logic      [NUM_PORTS-1:0]   PORT_LINK_RESTART
);

  typedef struct packed {
    // Pin synchronisers
    logic                       fs1;
    logic                       fs2;
    logic                       fs3;
    logic [4:0]                 tx1;
    logic [4:0]                 tx2;
    // Per-port state
    logic [NUM_PORTS-1:0][3:0]  adv;
    logic [NUM_PORTS-1:0][3:0]  tx_last;
    logic [NUM_PORTS-1:0]       tx_act;
    logic [NUM_PORTS-1:0]       link_inv;
    logic [NUM_PORTS-1:0]       restart;
    // Transmit hand-off to port engines
    logic [3:0]                 ptx_data;
    logic                       ptx_valid;
    logic [SLOT_W-1:0]          ptx_num;
    logic                       ptx_stb;
    // Receive-direction pins
    logic [3:0]                 rxd;
    logic                       rxv;
    logic                       col;
    logic                       crs;
    logic                       fdx;
    logic                       lnk;
    // Bus slave
    logic                       ap_act;
    logic                       ap_wr;
    logic [ADDR_W-1:0]          ap_addr;
    logic [31:0]                hrdata;
    logic                       hready;
    logic                       run;
    logic [IRQ_W-1:0]           irq_stat;
    logic [IRQ_W-1:0]           irq_mask;
    logic                       irq;
  } tpi_state_s;

  tpi_state_s st_r;
  tpi_state_s st_nxt;

  logic [PH_W-1:0]   phase;
  logic [SLOT_W-1:0] slot;
  logic              mux_clk;
  logic              marker;

  // ===========================================================================
  // Slot sequencer
  tpi_slot_seq u_seq (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .run     (st_r.run),
    .phase   (phase),
    .slot    (slot),
    .mux_clk (mux_clk),
    .marker  (marker)
  );

  // Nibble of one port from the packed engine bus
  function automatic logic [3:0] port_nib(input logic [NUM_PORTS*4-1:0] v,
                                          input logic [SLOT_W-1:0] p);
    port_nib = v[p*4 +: 4];
  endfunction

  // ===========================================================================
  // Next-state logic
  always_comb begin
    logic [SLOT_W-1:0] rx_port;
    logic              force_edge;
    logic              launch;
    logic              capture;
    logic              wr_go;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;
    rx_port    = '0;
    force_edge = 1'b0;
    launch     = 1'b0;
    capture    = 1'b0;
    wr_go      = 1'b0;
    irq_set    = '0;
    irq_clr    = '0;
    st_nxt     = st_r;

    // Two-stage synchronisers; stage two is read, and force stage three only for edge detection
    st_nxt.fs1 = HALF_DUPLEX_FORCE_IN;
    st_nxt.fs2 = st_r.fs1;
    st_nxt.fs3 = st_r.fs2;
    st_nxt.tx1 = {TX_NIBBLE_VALID, TX_NIBBLE};
    st_nxt.tx2 = st_r.tx1;

    launch  = st_r.run && (phase == PH_LAUNCH);
    capture = st_r.run && (phase == PH_LAST);
    rx_port = SLOT_W'(slot + RX_LEAD);

    force_edge      = st_r.fs2 ^ st_r.fs3;
    st_nxt.restart  = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // Invalid flag drops once the engine has taken link down
      if (!PORT_LINK[p]) begin
        st_nxt.link_inv[p] = 1'b0;
      end
      if (force_edge && (slot == SLOT_W'(p))) begin
        st_nxt.restart[p]  = 1'b1;
        st_nxt.link_inv[p] = 1'b1;
      end
      if (PORT_ADV_LATCH[p]) begin
        if (!st_r.fs2) begin
          st_nxt.adv[p] = ADV_HALF_ONLY;
        end else begin
          st_nxt.adv[p] = st_r.tx_last[p];
        end
      end
    end
    irq_set[IRQ_FORCE_EDG] = force_edge;
    irq_set[IRQ_ADV_LATCH] = |PORT_ADV_LATCH;

    // Transmit capture at the end of the slot
    st_nxt.ptx_stb = 1'b0;
    if (capture) begin
      st_nxt.tx_act[slot] = st_r.tx2[4];
      st_nxt.ptx_stb      = 1'b1;
      st_nxt.ptx_valid    = st_r.tx2[4];
      st_nxt.ptx_num      = slot;
      if (st_r.tx2[4]) begin
        st_nxt.tx_last[slot] = st_r.tx2[3:0];
        st_nxt.ptx_data      = st_r.tx2[3:0];
      end
    end

    // Receive-direction pins change with the falling clock edge, except the duplex flag, which drops whenever half duplex is forced
    if (launch) begin
      st_nxt.rxv = PORT_RX_VALID[rx_port];
      st_nxt.rxd = PORT_RX_VALID[rx_port] ?
                   port_nib(PORT_RX_DATA, rx_port) : 4'h0;
      st_nxt.col = PORT_COLLISION[rx_port];
      irq_set[IRQ_COLL] = PORT_COLLISION[rx_port];
      st_nxt.fdx = PORT_FULL_DUPLEX[rx_port] && st_r.fs2;
      st_nxt.crs = PORT_CARRIER[rx_port] ||
                   (!st_nxt.fdx && st_r.tx_act[rx_port]);
      st_nxt.lnk = PORT_LINK[rx_port] && !st_r.link_inv[rx_port];
    end else if (!st_r.fs2) begin
      st_nxt.fdx = 1'b0;
    end

    // =========================================================================
    // AHB-Lite slave, zero wait states
    st_nxt.hready = 1'b1;
    wr_go = st_r.ap_act && st_r.ap_wr;
    if (wr_go) begin
      unique case (st_r.ap_addr)
        REG_CTRL:     st_nxt.run      = HWDATA[CTRL_RUN_BIT];
        REG_IRQ_STAT: irq_clr         = HWDATA[IRQ_W-1:0];
        REG_IRQ_MASK: st_nxt.irq_mask = HWDATA[IRQ_W-1:0];
        default:      st_nxt.run      = st_nxt.run;
      endcase
    end

    // Address phase capture, word writes only
    st_nxt.ap_act  = HSEL && HREADY && HTRANS[HTRANS_ACT];
    st_nxt.ap_wr   = HWRITE && (HSIZE == HSIZE_WORD);
    st_nxt.ap_addr = HADDR[ADDR_W-1:0];

    // Read data prepared for the data phase
    st_nxt.hrdata = '0;
    if (st_nxt.ap_act && !HWRITE) begin
      unique case (HADDR[ADDR_W-1:0])
        REG_CTRL: begin
          st_nxt.hrdata[CTRL_RUN_BIT] = st_r.run;
        end
        REG_STATUS: begin
          st_nxt.hrdata[ST_INV_LSB +: NUM_PORTS] = st_r.link_inv;
          st_nxt.hrdata[ST_ACT_LSB +: NUM_PORTS] = st_r.tx_act;
          st_nxt.hrdata[ST_FORCE_BIT]            = st_r.fs2;
          st_nxt.hrdata[ST_SLOT_LSB +: SLOT_W]   = slot;
        end
        REG_IRQ_STAT: st_nxt.hrdata[IRQ_W-1:0] = st_r.irq_stat;
        REG_IRQ_MASK: st_nxt.hrdata[IRQ_W-1:0] = st_r.irq_mask;
        REG_ADV:      st_nxt.hrdata             = 32'(st_r.adv);
        default:      st_nxt.hrdata             = '0;
      endcase
    end

    // Sticky events: a new event beats a same-cycle clear
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // ===========================================================================
  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r          <= '0;
      st_r.hready   <= 1'b1;
      st_r.run      <= CTRL_RUN_RST;
    end else begin
      st_r          <= st_nxt;
    end
  end

  // ===========================================================================
  // Outputs, all straight from flip-flops except HRESP, tied to OKAY
  assign HRDATA                = st_r.hrdata;
  assign HREADYOUT             = st_r.hready;
  assign HRESP                 = HRESP_OKAY;
  assign IRQ                   = st_r.irq;
  assign MUX_PORT_CLOCK        = mux_clk;
  assign SLOT_FRAME_MARKER     = marker;
  assign RX_NIBBLE             = st_r.rxd;
  assign RX_NIBBLE_VALID       = st_r.rxv;
  assign SLOT_COLLISION        = st_r.col;
  assign SLOT_CARRIER_SENSE    = st_r.crs;
  assign SLOT_FULL_DUPLEX_FLAG = st_r.fdx;
  assign SLOT_LINK_UP          = st_r.lnk;
  assign PORT_TX_DATA          = st_r.ptx_data;
  assign PORT_TX_VALID         = st_r.ptx_valid;
  assign PORT_TX_NUM           = st_r.ptx_num;
  assign PORT_TX_STROBE        = st_r.ptx_stb;
  assign PORT_ADV_MODES        = st_r.adv;
  assign PORT_LINK_RESTART     = st_r.restart;

endmodule

// ==== sim/tpi_mux_checker.sv ====
// Timing checks on the device end of the multiplexed port interface
`timescale 1ns/1ps

module tpi_mux_checker
  import tpi_pkg::*;
(
  input wire logic                   CLK_SYS,
  input wire logic                   RST_B,
  input wire logic                   MUX_PORT_CLOCK,
  input wire logic                   SLOT_FRAME_MARKER,
  input wire logic [3:0]             RX_NIBBLE,
  input wire logic                   RX_NIBBLE_VALID,
  input wire logic                   SLOT_COLLISION,
  input wire logic                   SLOT_CARRIER_SENSE,
  input wire logic                   SLOT_FULL_DUPLEX_FLAG,
  input wire logic                   SLOT_LINK_UP,
  input wire logic                   HALF_DUPLEX_FORCE_IN,
  input wire logic [NUM_PORTS-1:0]   PORT_ADV_LATCH,
  input wire logic [SLOT_W-1:0]      PORT_TX_NUM,
  input wire logic                   PORT_TX_STROBE,
  input wire logic [NUM_PORTS*4-1:0] PORT_ADV_MODES,
  input wire logic [NUM_PORTS-1:0]   PORT_LINK_RESTART
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic [5:0] gap_r;
  logic       seen_r;

  // Cycles since the last marker rise
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b0;
    end else if ($rose(SLOT_FRAME_MARKER)) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b1;
    end else begin
      gap_r  <= gap_r + 6'h01;
    end
  end

  sequence clk_wave;
    MUX_PORT_CLOCK ##1 !MUX_PORT_CLOCK [*3] ##1 MUX_PORT_CLOCK;
  endsequence
  sequence mark_pulse;
    SLOT_FRAME_MARKER [*5] ##1 !SLOT_FRAME_MARKER;
  endsequence

  clock_wave_a: assert property ($rose(MUX_PORT_CLOCK) |=> clk_wave)
    else $error("port clock not 20 MHz");
  marker_width_a: assert property ($rose(SLOT_FRAME_MARKER) |-> mark_pulse)
    else $error("marker width wrong");
  marker_period_a: assert property (
    $rose(SLOT_FRAME_MARKER) && seen_r |-> gap_r == 6'h27)
    else $error("marker period wrong");
  marker_align_a: assert property (
    $rose(SLOT_FRAME_MARKER) |-> $rose(MUX_PORT_CLOCK))
    else $error("marker not on slot start");
  marker_slot_a: assert property (
    $rose(SLOT_FRAME_MARKER) && seen_r |-> PORT_TX_STROBE
    && PORT_TX_NUM == SLOT_LAST) else $error("slot before marker not last");
  strobe_rate_a: assert property (
    PORT_TX_STROBE |=> !PORT_TX_STROBE [*4] ##1 PORT_TX_STROBE)
    else $error("transmit capture not once per slot");
  rx_launch_a: assert property (!$stable({RX_NIBBLE,
    RX_NIBBLE_VALID, SLOT_COLLISION, SLOT_CARRIER_SENSE, SLOT_LINK_UP})
    |-> $fell(MUX_PORT_CLOCK)) else $error("slot outputs off falling edge");
  rx_zero_a: assert property (!RX_NIBBLE_VALID |-> RX_NIBBLE == 4'h0)
    else $error("nibble without valid");
  duplex_low_a: assert property (
    !HALF_DUPLEX_FORCE_IN [*5] |-> !SLOT_FULL_DUPLEX_FLAG)
    else $error("duplex high while forced half");
  restart_edge_a: assert property (
    $changed(HALF_DUPLEX_FORCE_IN) |-> ##[1:5] (|PORT_LINK_RESTART))
    else $error("no link restart after force edge");
  restart_one_a: assert property (
    (|PORT_LINK_RESTART) |-> $onehot(PORT_LINK_RESTART)
    ##1 PORT_LINK_RESTART == 8'h00) else $error("restart pulse malformed");
  adv_half_a: assert property (
    !HALF_DUPLEX_FORCE_IN [*5] ##0 PORT_ADV_LATCH[3]
    |=> PORT_ADV_MODES[15:12] == ADV_HALF_ONLY)
    else $error("half duplex not advertised");
endmodule

bind tpi_mux_if tpi_mux_checker tpi_mux_checker_inst (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .MUX_PORT_CLOCK(MUX_PORT_CLOCK),
  .SLOT_FRAME_MARKER(SLOT_FRAME_MARKER), .RX_NIBBLE(RX_NIBBLE),
  .RX_NIBBLE_VALID(RX_NIBBLE_VALID), .SLOT_COLLISION(SLOT_COLLISION),
  .SLOT_CARRIER_SENSE(SLOT_CARRIER_SENSE), .SLOT_LINK_UP(SLOT_LINK_UP),
  .SLOT_FULL_DUPLEX_FLAG(SLOT_FULL_DUPLEX_FLAG),
  .HALF_DUPLEX_FORCE_IN(HALF_DUPLEX_FORCE_IN),
  .PORT_ADV_LATCH(PORT_ADV_LATCH), .PORT_TX_NUM(PORT_TX_NUM),
  .PORT_TX_STROBE(PORT_TX_STROBE), .PORT_ADV_MODES(PORT_ADV_MODES),
  .PORT_LINK_RESTART(PORT_LINK_RESTART));

// ==== sim/tpi_ctrl_model.sv ====
// Controller model: follows slots, drives transmit, samples receive
`timescale 1ns/1ps

module tpi_ctrl_model
  import tpi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              mux_clk,
  input  wire logic              marker,
  input  wire logic              tx_on,
  input  wire logic [3:0]        tx_base,
  output logic      [3:0]        tx_nib,
  output logic                   tx_val,
  output logic      [SLOT_W-1:0] rx_port,
  output logic                   rx_take,
  output int                     mark_err
);
  logic              prev;
  logic [SLOT_W-1:0] slot;
  logic [SLOT_W-1:0] s;

  // Slot number that the next port clock rise opens
  assign s = marker ? MARK_PORT : slot + 3'h1;

  // Edge detection of the port clock in the system domain
  always @(posedge clk) begin
    if (!rst_b) begin
      rx_take  <= 1'b0;
      rx_port  <= 3'h0;
      prev     <= 1'b0;
      slot     <= 3'h0;
      tx_val   <= 1'b0;
      tx_nib   <= 4'h0;
      mark_err <= 0;
    end else begin
      prev    <= mux_clk;
      rx_take <= !mux_clk && prev;
      if (mux_clk && !prev) begin
        slot   <= s;
        tx_val <= tx_on;
        tx_nib <= tx_on ? tx_base + {1'b0, s} : ~tx_nib;
      end
      if (!mux_clk && prev) begin
        if (marker !== (slot == MARK_PORT)) mark_err <= mark_err + 1;
        rx_port <= slot + RX_LEAD;
      end
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the multiplexed port interface
`timescale 1ns/1ps

module testbench
  import tpi_pkg::*;
;
  logic CLK_SYS = 0, RST_B = 0, HSEL = 0, HWRITE = 0, F = 0, chk_rx = 0;
  logic tx_on = 0, tx_act = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, RXD = 0, rd;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 0, p, PORT_TX_NUM, rx_port;
  logic [3:0] TXN, RX_NIBBLE, PORT_TX_DATA, tx_base = 0;
  logic [7:0] RXV = 0, COL = 0, CRS = 0, LNK = 0, FD = 0, LAT = 0, RST_P;
  logic [31:0] ADV;
  logic HREADYOUT, HRESP, IRQ, MCK, MRK, RXDV, SCOL, SCRS, SDUP, SLNK, TXV;
  logic PORT_TX_VALID, PORT_TX_STROBE, rx_take;
  int n_mismatch = 0, checked = 0, mark_err, i, n;

  always #5 CLK_SYS = ~CLK_SYS;

  tpi_mux_if tpi_mux_if_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .MUX_PORT_CLOCK(MCK),
    .SLOT_FRAME_MARKER(MRK), .RX_NIBBLE(RX_NIBBLE), .RX_NIBBLE_VALID(RXDV),
    .SLOT_COLLISION(SCOL), .SLOT_CARRIER_SENSE(SCRS),
    .SLOT_FULL_DUPLEX_FLAG(SDUP), .SLOT_LINK_UP(SLNK),
    .HALF_DUPLEX_FORCE_IN(F), .TX_NIBBLE(TXN), .TX_NIBBLE_VALID(TXV),
    .PORT_RX_DATA(RXD), .PORT_RX_VALID(RXV), .PORT_COLLISION(COL),
    .PORT_CARRIER(CRS), .PORT_LINK(LNK), .PORT_FULL_DUPLEX(FD),
    .PORT_ADV_LATCH(LAT), .PORT_TX_DATA(PORT_TX_DATA),
    .PORT_TX_VALID(PORT_TX_VALID), .PORT_TX_NUM(PORT_TX_NUM),
    .PORT_TX_STROBE(PORT_TX_STROBE), .PORT_ADV_MODES(ADV),
    .PORT_LINK_RESTART(RST_P));
  tpi_ctrl_model tpi_ctrl_model_inst (.clk(CLK_SYS), .rst_b(RST_B),
    .mux_clk(MCK), .marker(MRK), .tx_on(tx_on), .tx_base(tx_base),
    .tx_nib(TXN), .tx_val(TXV), .rx_port(rx_port), .rx_take(rx_take),
    .mark_err(mark_err));

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (e !== g) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1; HTRANS <= 2'h2; HADDR <= {24'h0, a}; HWRITE <= w;
    HSIZE <= HSIZE_WORD;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL <= 0; HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge CLK_SYS);
  endtask

  // Slot outputs compared against the port selected by the model
  always @(posedge CLK_SYS) begin
    if (chk_rx && rx_take) begin
      chk("slot", {RXV[rx_port] ? RXD[4*rx_port+:4] : 4'h0,
        RXV[rx_port], COL[rx_port], CRS[rx_port] |
        (!(FD[rx_port] & F) & tx_act), FD[rx_port] & F, LNK[rx_port]},
        {RX_NIBBLE, RXDV, SCOL, SCRS, SDUP, SLNK});
    end
  end

  task automatic t_regs();
    ahb(0, REG_CTRL, 0); chk("ctrl", 32'h1, rd);
    chk("resp", HRESP_OKAY, HRESP);
    ahb(0, REG_IRQ_MASK, 0); chk("mask", 32'h0, rd);
    ahb(1, 8'h40, 32'hffff_ffff); ahb(0, 8'h40, 0); chk("unmapped", 0, rd);
    $display("test regs done");
  endtask
  task automatic t_rx(input logic [31:0] k, input logic f);
    RXD <= 32'h7654_3210 ^ k; RXV <= 8'h5a ^ k[7:0]; COL <= 8'h3c ^ k[7:0];
    CRS <= 8'h96 ^ k[7:0]; LNK <= 8'h00; FD <= 8'hcc ^ k[7:0]; F <= f;
    // Link dropped briefly so a force edge leaves no port invalid
    wt(50); LNK <= 8'hff; wt(50);
    chk_rx <= 1; wt(100); chk_rx <= 0;
    $display("test rx done");
  endtask
  task automatic t_tx();
    tx_base <= 4'h9; tx_on <= 1; F <= 0; CRS <= 8'h00; wt(100);
    tx_act <= 1; chk_rx <= 1;
    repeat (16) begin
      i = 0;
      do begin @(posedge CLK_SYS); i++; end while (!PORT_TX_STROBE && i < 20);
      chk("tx", {1'b1, 4'h9 + {1'b0, PORT_TX_NUM}},
        {PORT_TX_VALID, PORT_TX_DATA});
    end
    chk_rx <= 0; tx_on <= 0; wt(100); tx_act <= 0;
    $display("test tx done");
  endtask
  task automatic t_force();
    ahb(1, REG_IRQ_STAT, 32'h7); ahb(1, REG_IRQ_MASK, 32'h1);
    n = 0; p = 0;
    repeat (2) begin
      F <= ~F;
      for (i = 0; i < 12; i++) begin
        @(posedge CLK_SYS);
        if (RST_P !== 8'h00) n++;
        p = p | RST_P[2:0];
      end
    end
    chk("restarts", 2, n);
    chk("irq", 1, IRQ);
    ahb(0, REG_STATUS, 0); chk("invalid", 1, rd[7:0] !== 8'h00);
    ahb(1, REG_IRQ_STAT, 32'h1); wt(2); chk("irq clr", 0, IRQ);
    LNK <= 8'h00; wt(100); LNK <= 8'hff;
    ahb(0, REG_STATUS, 0); chk("cleared", 0, rd[7:0]);
    ahb(1, REG_IRQ_MASK, 32'h0);
    $display("test force done");
  endtask
  task automatic t_adv();
    F <= 0; wt(10); LAT <= 8'h08; wt(1); LAT <= 0; wt(2);
    chk("adv half", ADV_HALF_ONLY, ADV[15:12]);
    F <= 1; tx_base <= 4'h4; tx_on <= 1; wt(60); LAT <= 8'h08; wt(1);
    LAT <= 0; wt(2); tx_on <= 0;
    chk("adv tx", 4'h7, ADV[15:12]);
    ahb(0, REG_ADV, 0); chk("adv reg", 4'h7, rd[15:12]);
    ahb(0, REG_IRQ_STAT, 0); chk("adv irq", 1, rd[IRQ_ADV_LATCH]);
    $display("test adv done");
  endtask

  task automatic stop_test();
    chk("marker sampling", 0, mark_err);
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end
  initial begin
    wt(2); RST_B <= 1; wt(1);
    t_regs();
    t_rx(32'h0, 1);
    t_rx(32'hffff_ffff, 0);
    t_tx();
    t_force();
    t_adv();
    stop_test();
  end
endmodule
